// [led_dimming_control.sv]
// Brightness, flash, dimming-input sampling and ramp control of a three-string LED driver
`timescale 1ns/100ps
`include "led_dim_params.svh"
module led_dimming_control #(
   parameter int unsigned MS_CYCLES = `CLK_KHZ,
   parameter int unsigned SD_FAST   = `SD_FAST_US * `SR_FAST_KHZ / `US_PER_MS,
   parameter int unsigned SD_MID    = `SD_MID_US * `SR_MID_KHZ / `US_PER_MS,
   parameter int unsigned SD_SLOW   = `SD_SLOW_US * `SR_SLOW_KHZ / `US_PER_MS
)(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire led_dim_pkg::reg_req_t i_reg_req,
   output logic [7:0]                 o_reg_rdata,
   input  wire logic                  i_pwm,
   input  wire logic                  i_protect_event,
   output logic [2:0]                 o_string_en,
   output logic [10:0]                o_led_code,
   output logic                       o_exp_map,
   output logic                       o_flash_active,
   output logic [2:0]                 o_flash_level,
   output logic                       o_peak_limit_3a,
   output logic [1:0]                 o_peak_limit_sel,
   output logic                       o_freq_select,
   output logic                       o_shutdown
);
   // ---------------------------------------------------------------
   // Synchronisers and timebases
   // ---------------------------------------------------------------
   logic        pwm_m_r, pwm_s_r, prot_m_r, prot_s_r;
   logic [15:0] ms_cnt_r, ms_cnt_nxt;
   logic        ms_tick_r, ms_tick_nxt;
   logic [5:0]  acc_r, acc_nxt, acc_inc, acc_mod;
   logic        s_tick_r, s_tick_nxt;
   logic [7:0]  ctrl_r, ctrl_nxt, flash_r, flash_nxt, pcfg_r, pcfg_nxt;
   logic [7:0]  sw_r, sw_nxt, slope_r, slope_nxt, lo_r, lo_nxt, hi_r, hi_nxt;

   always_comb
   begin
      ms_tick_nxt = (ms_cnt_r == 16'(MS_CYCLES - 1));
      ms_cnt_nxt  = ms_tick_nxt ? 16'h0000 : ms_cnt_r + 16'h0001;
      // Fractional accumulator makes 24, 4 or 0.8 MHz average out of 40 MHz
      case (pcfg_r[`PWM_SR_MSB:0])
         2'b00:   begin acc_inc = `SR_ONE_INC;  acc_mod = `SR_SLOW_MOD; end
         2'b01:   begin acc_inc = `SR_ONE_INC;  acc_mod = `SR_MID_MOD;  end
         default: begin acc_inc = `SR_FAST_INC; acc_mod = `SR_FAST_MOD; end
      endcase
      s_tick_nxt = (acc_r + acc_inc >= acc_mod);
      acc_nxt    = s_tick_nxt ? acc_r + acc_inc - acc_mod : acc_r + acc_inc;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         {pwm_m_r, pwm_s_r, prot_m_r, prot_s_r} <= 4'h0;
         ms_cnt_r  <= 16'h0000;
         ms_tick_r <= 1'b0;
         acc_r     <= 6'h00;
         s_tick_r  <= 1'b0;
      end
      else
      begin
         pwm_m_r   <= i_pwm;
         pwm_s_r   <= pwm_m_r;
         prot_m_r  <= i_protect_event;
         prot_s_r  <= prot_m_r;
         ms_cnt_r  <= ms_cnt_nxt;
         ms_tick_r <= ms_tick_nxt;
         acc_r     <= acc_nxt;
         s_tick_r  <= s_tick_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Registers and flash control
   // ---------------------------------------------------------------
   logic        flash_act_r, flash_act_nxt;
   logic [9:0]  flash_ms_r, flash_ms_nxt;
   logic [10:0] reg_tgt_r, reg_tgt_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        flash_end, flash_start, shut_r;
   logic [10:0] code_r;
   led_dim_pkg::bright_mode_t mode;

   assign mode = led_dim_pkg::bright_mode_t'(pcfg_r[`PWM_MODE_MSB:`PWM_MODE_LSB]);

   always_comb
   begin
      {ctrl_nxt, pcfg_nxt, sw_nxt, slope_nxt} = {ctrl_r, pcfg_r, sw_r, slope_r};
      {lo_nxt, hi_nxt, reg_tgt_nxt, flash_act_nxt} = {lo_r, hi_r, reg_tgt_r, flash_act_r};
      flash_nxt    = flash_r;
      flash_ms_nxt = flash_ms_r;
      rdata_nxt    = rdata_r;
      flash_end    = flash_act_r & (prot_s_r | (ms_tick_r & (flash_ms_r == 10'h000)));
      flash_start  = 1'b0;
      if (flash_act_r && ms_tick_r)
         flash_ms_nxt = flash_ms_r - 10'h001;
      if (flash_end)
      begin
         flash_act_nxt = 1'b0;
         flash_nxt[`FLASH_EN_BIT] = 1'b0;
      end
      if (i_reg_req.wr)
      begin
         case (i_reg_req.addr)
            `REG_CTRL:      ctrl_nxt  = i_reg_req.wdata;
            `REG_PWM_CFG:   pcfg_nxt  = i_reg_req.wdata;
            `REG_SWITCH:    sw_nxt    = i_reg_req.wdata;
            `REG_SLOPE:     slope_nxt = i_reg_req.wdata;
            `REG_BRIGHT_LO: lo_nxt    = i_reg_req.wdata;
            `REG_BRIGHT_HI:
            begin
               hi_nxt      = i_reg_req.wdata;
               // Only the high write commits the code
               reg_tgt_nxt = {i_reg_req.wdata, lo_r[`BRIGHT_LO_MSB:0]};
            end
            `REG_FLASH:
            begin
               // Host write wins over a same-cycle hardware clear
               flash_nxt   = i_reg_req.wdata;
               flash_start = i_reg_req.wdata[`FLASH_EN_BIT] & (~flash_act_r | flash_end);
            end
            default: ;
         endcase
      end
      if (flash_start)
      begin
         flash_act_nxt = 1'b1;
         flash_ms_nxt  = 10'((32'(i_reg_req.wdata[`FLASH_T_MSB:`FLASH_T_LSB]) + 32'd1)
                             * `FLASH_STEP_MS - 32'd1);
      end
      if (i_reg_req.rd)
      begin
         case (i_reg_req.addr)
            `REG_CTRL:       rdata_nxt = ctrl_r;
            `REG_FLASH:      rdata_nxt = flash_r;
            `REG_PWM_CFG:    rdata_nxt = pcfg_r;
            `REG_SWITCH:     rdata_nxt = sw_r;
            `REG_SLOPE:      rdata_nxt = slope_r;
            `REG_BRIGHT_LO:  rdata_nxt = lo_r;
            `REG_BRIGHT_HI:  rdata_nxt = hi_r;
            `REG_STAT_CODE:  rdata_nxt = code_r[10:3];
            `REG_STAT_FLAGS: rdata_nxt = {flash_act_r, shut_r, 3'h0, code_r[2:0]};
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         ctrl_r      <= `CTRL_RST;
         flash_r     <= `FLASH_RST;
         pcfg_r      <= `PWM_CFG_RST;
         sw_r        <= `SWITCH_RST;
         slope_r     <= `SLOPE_RST;
         lo_r        <= 8'h00;
         hi_r        <= 8'h00;
         reg_tgt_r   <= 11'h000;
         flash_act_r <= 1'b0;
         flash_ms_r  <= 10'h000;
         rdata_r     <= 8'h00;
      end
      else
      begin
         {ctrl_r, flash_r, pcfg_r, sw_r} <= {ctrl_nxt, flash_nxt, pcfg_nxt, sw_nxt};
         {slope_r, lo_r, hi_r}           <= {slope_nxt, lo_nxt, hi_nxt};
         reg_tgt_r   <= reg_tgt_nxt;
         flash_act_r <= flash_act_nxt;
         flash_ms_r  <= flash_ms_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Duty measurement, hysteresis and shutdown
   // ---------------------------------------------------------------
   logic [19:0] hcnt_r, hcnt_nxt, pcnt_r, pcnt_nxt, happ_r, happ_nxt, sd_lim;
   logic [19:0] lcnt_r, lcnt_nxt;
   logic        prev_r, prev_nxt, up_r, up_nxt, shut_nxt, accept;
   logic [2:0]  hys;

   assign hys = pcfg_r[`PWM_HYS_MSB:`PWM_HYS_LSB];

   always_comb
   begin
      {hcnt_nxt, pcnt_nxt, happ_nxt, lcnt_nxt} = {hcnt_r, pcnt_r, happ_r, lcnt_r};
      {prev_nxt, up_nxt, shut_nxt} = {prev_r, up_r, shut_r};
      accept = 1'b0;
      case (pcfg_r[`PWM_SR_MSB:0])
         2'b00:   sd_lim = 20'(SD_SLOW);
         2'b01:   sd_lim = 20'(SD_MID);
         default: sd_lim = 20'(SD_FAST);
      endcase
      if (s_tick_r)
      begin
         prev_nxt = pwm_s_r;
         lcnt_nxt = pwm_s_r ? 20'h00000 : lcnt_r + {19'h00000, lcnt_r < sd_lim};
         if (pwm_s_r)
            shut_nxt = 1'b0;
         // Count may already sit past a limit lowered by a rate change
         else if (lcnt_r >= sd_lim - 20'h00001 && mode == led_dim_pkg::MODE_PWM)
            shut_nxt = 1'b1;
         if (pwm_s_r && !prev_r)
         begin
            // Rising edge closes a period
            if (hcnt_r > happ_r)
               accept = up_r | (hcnt_r - happ_r > 20'(hys));
            else if (hcnt_r < happ_r)
               accept = ~up_r | (happ_r - hcnt_r > 20'(hys));
            accept   = accept & (pcnt_r != 20'h00000);
            hcnt_nxt = 20'h00001;
            pcnt_nxt = 20'h00001;
         end
         else
         begin
            hcnt_nxt = hcnt_r + {19'h00000, pwm_s_r & ~&hcnt_r};
            pcnt_nxt = pcnt_r + {19'h00000, ~&pcnt_r};
         end
      end
      if (accept)
      begin
         happ_nxt = hcnt_r;
         up_nxt   = hcnt_r > happ_r;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         {hcnt_r, pcnt_r, happ_r, lcnt_r} <= {4{20'h00000}};
         {prev_r, up_r, shut_r} <= 3'b010;
      end
      else
      begin
         {hcnt_r, pcnt_r, happ_r, lcnt_r} <= {hcnt_nxt, pcnt_nxt, happ_nxt, lcnt_nxt};
         {prev_r, up_r, shut_r} <= {prev_nxt, up_nxt, shut_nxt};
      end
   end

   // ---------------------------------------------------------------
   // Serial divider: high * 2047 / period, one quotient bit per cycle
   // ---------------------------------------------------------------
   led_dim_pkg::div_state_t dst_r, dst_nxt;
   logic [31:0] num_r, num_nxt, trial;
   logic [19:0] den_r, den_nxt;
   logic [10:0] q_r, q_nxt, duty_r, duty_nxt;
   logic [3:0]  bit_r, bit_nxt;

   always_comb
   begin
      dst_nxt = dst_r;
      {num_nxt, den_nxt, q_nxt, duty_nxt, bit_nxt} = {num_r, den_r, q_r, duty_r, bit_r};
      trial = {12'h000, den_r} << bit_r;
      case (dst_r)
         led_dim_pkg::DIV_IDLE:
            if (accept)
            begin
               num_nxt = 32'(hcnt_r) * `CODE_FULL;
               den_nxt = pcnt_r;
               q_nxt   = 11'h000;
               bit_nxt = 4'hA;
               dst_nxt = led_dim_pkg::DIV_RUN;
            end
         led_dim_pkg::DIV_RUN:
         begin
            if (num_r >= trial)
            begin
               num_nxt = num_r - trial;
               q_nxt   = q_r | (11'h001 << bit_r);
            end
            bit_nxt = bit_r - 4'h1;
            if (bit_r == 4'h0)
            begin
               duty_nxt = (num_r >= trial) ? (q_r | 11'h001) : q_r;
               dst_nxt  = led_dim_pkg::DIV_IDLE;
            end
         end
         default: dst_nxt = led_dim_pkg::DIV_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         dst_r  <= led_dim_pkg::DIV_IDLE;
         {num_r, den_r, q_r, duty_r, bit_r} <= {32'h0, 20'h0, 11'h0, 11'h0, 4'h0};
      end
      else
      begin
         dst_r  <= dst_nxt;
         {num_r, den_r, q_r, duty_r, bit_r} <= {num_nxt, den_nxt, q_nxt, duty_nxt, bit_nxt};
      end
   end

   // ---------------------------------------------------------------
   // Target selection and ramp
   // ---------------------------------------------------------------
   logic [10:0] tgt, code_nxt;
   logic [7:0]  step_r, step_nxt;
   logic        step;

   always_comb
   begin
      // Other mode codes are unsupported and keep the register code
      tgt = (mode == led_dim_pkg::MODE_PWM) ? duty_r : reg_tgt_r;
      if (!ctrl_r[`CTRL_CHIP_EN] || shut_r)
         tgt = 11'h000;
      step     = ms_tick_r && (step_r == slope_r);
      step_nxt = step_r;
      if (ms_tick_r)
         step_nxt = step ? 8'h00 : step_r + 8'h01;
      code_nxt = code_r;
      if (!ctrl_r[`CTRL_SLOPE_EN])
         code_nxt = tgt;
      else if (step && code_r < tgt)
         code_nxt = code_r + 11'h001;
      else if (step && code_r > tgt)
         code_nxt = code_r - 11'h001;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         code_r <= 11'h000;
         step_r <= 8'h00;
      end
      else
      begin
         code_r <= code_nxt;
         step_r <= step_nxt;
      end
   end

   assign o_reg_rdata      = rdata_r;
   assign o_string_en      = ctrl_r[`CTRL_STR_MSB:`CTRL_STR_LSB];
   assign o_led_code       = code_r;
   assign o_exp_map        = ctrl_r[`CTRL_EXP_MAP];
   assign o_flash_active   = flash_act_r;
   assign o_flash_level    = flash_r[`FLASH_LVL_MSB:0];
   assign o_peak_limit_3a  = flash_act_r;
   assign o_peak_limit_sel = sw_r[`SW_CL_MSB:`SW_CL_LSB];
   assign o_freq_select    = sw_r[`SW_FS_BIT];
   assign o_shutdown       = shut_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   flash_start_a: assert property (i_reg_req.wr && i_reg_req.addr == `REG_FLASH &&
      i_reg_req.wdata[`FLASH_EN_BIT] && !flash_act_r |=> flash_act_r && o_peak_limit_3a)
      else $error("flash did not start");
   flash_prot_a: assert property (flash_act_r && prot_s_r && !i_reg_req.wr |=>
      !flash_act_r && !flash_r[`FLASH_EN_BIT]) else $error("flash survived protection");
   flash_end_a: assert property ($fell(flash_act_r) && !$past(prot_s_r) |->
      $past(flash_ms_r) == 10'h000) else $error("flash ended early");
   code_commit_a: assert property (i_reg_req.wr && i_reg_req.addr == `REG_BRIGHT_HI |=>
      reg_tgt_r == {$past(i_reg_req.wdata), $past(lo_r[`BRIGHT_LO_MSB:0])})
      else $error("brightness code not committed");
   lo_hold_a: assert property (i_reg_req.wr && i_reg_req.addr == `REG_BRIGHT_LO |=>
      $stable(reg_tgt_r)) else $error("low write changed code");
   ramp_step_a: assert property (ctrl_r[`CTRL_SLOPE_EN] && !step |=> $stable(code_r))
      else $error("code moved between steps");
   ramp_dist_a: assert property ($past(ctrl_r[`CTRL_SLOPE_EN]) && $changed(code_r) |->
      (code_r - $past(code_r) == 11'h001) || ($past(code_r) - code_r == 11'h001))
      else $error("ramp step not one");
   chip_off_a: assert property (!ctrl_r[`CTRL_CHIP_EN] && !ctrl_r[`CTRL_SLOPE_EN]
      |=> o_led_code == 11'h000) else $error("disabled code not zero");
   shut_clear_a: assert property (shut_r && s_tick_r && pwm_s_r |=> !shut_r)
      else $error("shutdown not released");
   duty_range_a: assert property (dst_r == led_dim_pkg::DIV_RUN |->
      bit_r <= 4'hA ##[1:11] dst_r == led_dim_pkg::DIV_IDLE) else $error("divider overran");

   flash_run_c: cover property ($fell(flash_act_r) && !$past(prot_s_r));
   ramp_up_c:   cover property (ctrl_r[`CTRL_SLOPE_EN] && $rose(code_r == 11'h004));
   shut_c:      cover property ($rose(shut_r));
   duty_c:      cover property (mode == led_dim_pkg::MODE_PWM && $changed(duty_r));
endmodule

// [led_dim_params.svh]
// Register map, field positions, reset values and timing constants
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_CTRL          8'h10
`define REG_FLASH         8'h11
`define REG_PWM_CFG       8'h12
`define REG_SWITCH        8'h13
`define REG_SLOPE         8'h14
`define REG_BRIGHT_LO     8'h18
`define REG_BRIGHT_HI     8'h19
`define REG_STAT_CODE     8'h1A
`define REG_STAT_FLAGS    8'h1B
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CTRL_RST          8'h0E
`define FLASH_RST         8'h00
`define PWM_CFG_RST       8'h11
`define SWITCH_RST        8'h00
`define SLOPE_RST         8'h00
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_CHIP_EN      0
`define CTRL_STR_LSB      1
`define CTRL_STR_MSB      3
`define CTRL_EXP_MAP      4
`define CTRL_SLOPE_EN     5
`define FLASH_EN_BIT      7
`define FLASH_T_MSB       6
`define FLASH_T_LSB       3
`define FLASH_LVL_MSB     2
`define PWM_SR_MSB        1
`define PWM_HYS_MSB       4
`define PWM_HYS_LSB       2
`define PWM_MODE_MSB      7
`define PWM_MODE_LSB      5
`define SW_FS_BIT         0
`define SW_CL_MSB         2
`define SW_CL_LSB         1
`define BRIGHT_LO_MSB     2
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_KHZ           40000
`define US_PER_MS         1000
`define FLASH_STEP_MS     50
`define SR_FAST_KHZ       24000
`define SR_MID_KHZ        4000
`define SR_SLOW_KHZ       800
`define SD_FAST_US        600
`define SD_MID_US         3000
`define SD_SLOW_US        25000
`define SR_FAST_INC       6'h03
`define SR_FAST_MOD       6'h05
`define SR_MID_MOD        6'h0A
`define SR_SLOW_MOD       6'h32
`define SR_ONE_INC        6'h01
`define CODE_FULL         32'd2047
`endif

// [led_dim_pkg.sv]
// Shared types of the LED dimming control block
package led_dim_pkg;
   typedef enum logic [2:0] {MODE_REG = 3'b000, MODE_PWM = 3'b001} bright_mode_t;
   typedef enum {DIV_IDLE, DIV_RUN} div_state_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage

// [pwm_source_model.sv]
// Dimming pulse source model at the far side of the block
`timescale 1ns/100ps
module pwm_source_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_run,
   input  wire logic [15:0] i_high,
   input  wire logic [15:0] i_period,
   output logic             o_pwm
);
   logic [15:0] cnt_r;
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_run || (cnt_r >= i_period - 16'h0001))
         cnt_r <= 16'h0000;
      else
         cnt_r <= cnt_r + 16'h0001;
   end
   // Stopped source is held low, so the long-low shutdown can be provoked
   assign o_pwm = i_run && (cnt_r < i_high);
endmodule

// [led_dimming_control_test.sv]
// Self-checking testbench of the LED dimming control block
`timescale 1ns/100ps
`include "led_dim_params.svh"
module led_dimming_control_test;
   logic                  i_clk_sys;
   logic                  i_rst;
   led_dim_pkg::reg_req_t i_reg_req;
   logic                  i_pwm;
   logic                  i_protect_event;
   logic [7:0]            o_reg_rdata;
   logic [2:0]            o_string_en;
   logic [10:0]           o_led_code;
   logic                  o_exp_map;
   logic                  o_flash_active;
   logic [2:0]            o_flash_level;
   logic                  o_peak_limit_3a;
   logic [1:0]            o_peak_limit_sel;
   logic                  o_freq_select;
   logic                  o_shutdown;
   logic                  pwm_run;
   logic [15:0]           pwm_high;
   logic [7:0]            rd_val;
   int                    err_count;
   int                    check_count;
   // Shutdown delay in cycles for the sample-tick limits below, per rate
   int                    sd_cyc [3] = '{10000, 1200, 600};
   logic [7:0]            sd_cfg [3] = '{8'h20, 8'h21, 8'h22};

   // Limits exceed the source's low phase at every rate
   led_dimming_control #(.MS_CYCLES(40), .SD_FAST(360), .SD_MID(120), .SD_SLOW(200))
      u_led_dimming_control (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
      .i_pwm(i_pwm), .i_protect_event(i_protect_event), .o_string_en(o_string_en),
      .o_led_code(o_led_code), .o_exp_map(o_exp_map), .o_flash_active(o_flash_active),
      .o_flash_level(o_flash_level), .o_peak_limit_3a(o_peak_limit_3a),
      .o_peak_limit_sel(o_peak_limit_sel), .o_freq_select(o_freq_select), .o_shutdown(o_shutdown));
   pwm_source_model u_pwm_source_model (.i_clk_sys(i_clk_sys), .i_run(pwm_run),
      .i_high(pwm_high), .i_period(16'h00C8), .o_pwm(i_pwm));

   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #2;
   endtask

   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      cyc(1);
      i_reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      cyc(1);
      i_reg_req.wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
      cyc(1);
      i_reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      cyc(1);
      i_reg_req.rd = 1'b0;
      data = o_reg_rdata;
   endtask

   task automatic chk(input string name, input logic [15:0] lo, input logic [15:0] hi,
                      input logic [15:0] got);
      check_count++;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
         err_count++;
         $display("unexpected %s expected %0h..%0h seen %0h", name, lo, hi, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if ((err_count == 0) && (check_count > 0))
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge i_clk_sys);
      err_count++;
      close_out();
   end

   initial
   begin
      i_rst = 1'b1;
      i_reg_req = '0;
      i_protect_event = 1'b0;
      pwm_run = 1'b0;
      pwm_high = 16'h0000;
      err_count = 0;
      check_count = 0;
      repeat (8) @(posedge i_clk_sys);
      #2;
      i_rst = 1'b0;
      // ------------------------------------------------------------
      // Reset state, strings and register code
      // ------------------------------------------------------------
      chk("string_en", 16'h0007, 16'h0007, 16'(o_string_en));
      chk("led_code", 16'h0000, 16'h0000, 16'(o_led_code));
      rd_reg(`REG_PWM_CFG, rd_val);
      chk("pwm_cfg", 16'h0011, 16'h0011, 16'(rd_val));
      rd_reg(8'h05, rd_val);
      chk("unmapped", 16'h0000, 16'h0000, 16'(rd_val));
      wr_reg(`REG_CTRL, 8'h03);
      cyc(1);
      chk("string_en", 16'h0001, 16'h0001, 16'(o_string_en));
      wr_reg(`REG_CTRL, 8'h0F);
      wr_reg(`REG_BRIGHT_LO, 8'h05);
      cyc(3);
      chk("led_code", 16'h0000, 16'h0000, 16'(o_led_code));
      wr_reg(`REG_BRIGHT_HI, 8'hAB);
      cyc(2);
      chk("led_code", 16'h055D, 16'h055D, 16'(o_led_code));
      rd_reg(`REG_STAT_CODE, rd_val);
      chk("stat_code", 16'h00AB, 16'h00AB, 16'(rd_val));
      wr_reg(`REG_CTRL, 8'h1F);
      cyc(1);
      chk("exp_map", 16'h0001, 16'h0001, 16'(o_exp_map));
      // ------------------------------------------------------------
      // Flash timeout and protection abort
      // ------------------------------------------------------------
      wr_reg(`REG_SWITCH, 8'h05);
      wr_reg(`REG_FLASH, 8'h83);
      cyc(1);
      chk("flash", 16'h0001, 16'h0001, 16'(o_flash_active));
      chk("level", 16'h0003, 16'h0003, 16'(o_flash_level));
      chk("limit", 16'h0006, 16'h0006, 16'({o_peak_limit_3a, o_peak_limit_sel}));
      chk("freq", 16'h0001, 16'h0001, 16'(o_freq_select));
      rd_reg(`REG_STAT_FLAGS, rd_val);
      chk("stat_flags", 16'h0085, 16'h0085, 16'(rd_val));
      cyc(1900);
      chk("flash", 16'h0001, 16'h0001, 16'(o_flash_active));
      cyc(150);
      chk("limit", 16'h0002, 16'h0002, 16'({o_peak_limit_3a, o_peak_limit_sel}));
      rd_reg(`REG_FLASH, rd_val);
      chk("flash_reg", 16'h0003, 16'h0003, 16'({o_flash_active, rd_val}));
      wr_reg(`REG_FLASH, 8'h83);
      cyc(2);
      i_protect_event = 1'b1;
      cyc(4);
      i_protect_event = 1'b0;
      rd_reg(`REG_FLASH, rd_val);
      chk("flash_reg", 16'h0003, 16'h0003, 16'({o_flash_active, rd_val}));
      // ------------------------------------------------------------
      // Ramp up on a code write and ramp down on chip disable
      // ------------------------------------------------------------
      wr_reg(`REG_BRIGHT_LO, 8'h00);
      wr_reg(`REG_BRIGHT_HI, 8'h00);
      wr_reg(`REG_SLOPE, 8'h00);
      wr_reg(`REG_CTRL, 8'h2F);
      wr_reg(`REG_BRIGHT_HI, 8'h01);
      cyc(100);
      chk("ramp_up", 16'h0001, 16'h0004, 16'(o_led_code));
      cyc(300);
      chk("ramp_up", 16'h0008, 16'h0008, 16'(o_led_code));
      wr_reg(`REG_CTRL, 8'h2E);
      cyc(100);
      chk("ramp_dn", 16'h0004, 16'h0007, 16'(o_led_code));
      cyc(300);
      chk("ramp_dn", 16'h0000, 16'h0000, 16'(o_led_code));
      // ------------------------------------------------------------
      // Input duty mode and hysteresis
      // ------------------------------------------------------------
      wr_reg(`REG_CTRL, 8'h0F);
      pwm_run = 1'b1;
      pwm_high = 16'h0064;
      wr_reg(`REG_PWM_CFG, 8'h21);
      cyc(1000);
      chk("duty_code", 16'h03FF, 16'h03FF, 16'(o_led_code));
      wr_reg(`REG_BRIGHT_HI, 8'hFF);
      cyc(3);
      chk("duty_code", 16'h03FF, 16'h03FF, 16'(o_led_code));
      pwm_high = 16'h0096;
      cyc(1000);
      chk("duty_code", 16'h05FF, 16'h05FF, 16'(o_led_code));
      wr_reg(`REG_PWM_CFG, 8'h39);
      pwm_high = 16'h008C;
      cyc(1000);
      chk("hys_hold", 16'h05FF, 16'h05FF, 16'(o_led_code));
      pwm_high = 16'h0050;
      cyc(1000);
      chk("hys_pass", 16'h0332, 16'h0332, 16'(o_led_code));
      pwm_high = 16'h0046;
      cyc(1000);
      chk("hys_same", 16'h02CC, 16'h02CC, 16'(o_led_code));
      // ------------------------------------------------------------
      // Long-low shutdown at every sample rate
      // ------------------------------------------------------------
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(`REG_PWM_CFG, sd_cfg[i]);
         pwm_high = 16'h0064;
         cyc(300);
         chk("shutdown", 16'h0000, 16'h0000, 16'(o_shutdown));
         pwm_high = 16'h0000;
         cyc(sd_cyc[i] * 7 / 10);
         chk("shutdown", 16'h0000, 16'h0000, 16'(o_shutdown));
         cyc(sd_cyc[i] * 6 / 10 + 10);
         chk("shutdown", 16'h0001, 16'h0001, 16'(o_shutdown));
      end
      close_out();
   end
endmodule
